/* smlt_pkg.sv */
// Package for the swap mode lane translator.
// Assumes a single clk_sys domain; used by all translator design files.
package smlt_pkg;

  localparam int CLK_MHZ = 125;

  // Byte enables are active low: 0 means the byte is enabled
  localparam logic [3:0] BE_ALL = 4'h0;
  localparam logic [3:0] BE_NONE = 4'hF;

  // Size codes on the local bus
  localparam logic [1:0] SIZ_LONG = 2'h0;
  localparam logic [1:0] SIZ_BYTE = 2'h1;
  localparam logic [1:0] SIZ_WORD = 2'h2;
  localparam logic [1:0] SIZ_TRI = 2'h3;

  // Page map entry field layout
  localparam int SWP_MODE_LSB = 0;
  localparam int SWP_D64_BIT = 2;

  typedef enum logic [1:0] {
    SMLT_NO_SWAP = 2'h0,
    SMLT_BYTE_SWAP = 2'h1,
    SMLT_WORD_SWAP = 2'h2,
    SMLT_LONG_SWAP = 2'h3
  } smlt_mode_e;

  // Local bus address and size pair
  typedef struct packed {
    logic [1:0] local_address_low_bits;
    logic [1:0] local_transfer_size_code;
  } smlt_local_s;

  // Result of a PCI to local translation
  typedef struct packed {
    logic legal;
    logic low_lane;
    smlt_local_s loc;
  } smlt_down_s;

  // Result of a local to PCI translation
  typedef struct packed {
    logic legal;
    logic low_lane;
    logic [3:0] be_n;
  } smlt_up_s;

  // Three-bit page swap select from a map entry
  typedef logic [2:0] smlt_swp_t;

endpackage : smlt_pkg

/* smlt_down_xlat.sv */
// PCI byte enables to local address-low and size, per swap mode.
// Pure combinational table; the top registers its result.
module smlt_down_xlat (
  input wire logic [3:0] be_n,
  input wire logic [1:0] mode,
  output smlt_pkg::smlt_down_s res
);

  function automatic smlt_pkg::smlt_down_s mk(
    input logic [1:0] a, input logic [1:0] s, input logic l);
    smlt_pkg::smlt_down_s r;
    r.legal = 1'b1;
    r.low_lane = l;
    r.loc.local_address_low_bits = a;
    r.loc.local_transfer_size_code = s;
    return r;
  endfunction : mk

  always_comb begin
    res = '0;
    unique case ({be_n, mode})
      // Single bytes
      {4'hE, 2'h0}: res = mk(2'h0, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'hE, 2'h1}: res = mk(2'h1, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'hE, 2'h2}: res = mk(2'h2, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'hE, 2'h3}: res = mk(2'h3, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'hD, 2'h0}: res = mk(2'h1, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'hD, 2'h1}: res = mk(2'h0, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'hD, 2'h2}: res = mk(2'h3, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'hD, 2'h3}: res = mk(2'h2, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'hB, 2'h0}: res = mk(2'h2, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'hB, 2'h1}: res = mk(2'h3, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'hB, 2'h2}: res = mk(2'h0, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'hB, 2'h3}: res = mk(2'h1, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'h7, 2'h0}: res = mk(2'h3, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'h7, 2'h1}: res = mk(2'h2, smlt_pkg::SIZ_BYTE, 1'b0);
      {4'h7, 2'h2}: res = mk(2'h1, smlt_pkg::SIZ_BYTE, 1'b1);
      {4'h7, 2'h3}: res = mk(2'h0, smlt_pkg::SIZ_BYTE, 1'b1);
      // Aligned words
      {4'hC, 2'h0}: res = mk(2'h0, smlt_pkg::SIZ_WORD, 1'b1);
      {4'hC, 2'h1}: res = mk(2'h0, smlt_pkg::SIZ_WORD, 1'b1);
      {4'hC, 2'h2}: res = mk(2'h2, smlt_pkg::SIZ_WORD, 1'b0);
      {4'hC, 2'h3}: res = mk(2'h2, smlt_pkg::SIZ_WORD, 1'b0);
      {4'h3, 2'h0}: res = mk(2'h2, smlt_pkg::SIZ_WORD, 1'b0);
      {4'h3, 2'h1}: res = mk(2'h2, smlt_pkg::SIZ_WORD, 1'b0);
      {4'h3, 2'h2}: res = mk(2'h0, smlt_pkg::SIZ_WORD, 1'b1);
      {4'h3, 2'h3}: res = mk(2'h0, smlt_pkg::SIZ_WORD, 1'b1);
      // Unaligned words
      {4'h9, 2'h0}: res = mk(2'h1, smlt_pkg::SIZ_WORD, 1'b0);
      {4'h9, 2'h3}: res = mk(2'h1, smlt_pkg::SIZ_WORD, 1'b0);
      {4'h6, 2'h1}: res = mk(2'h1, smlt_pkg::SIZ_WORD, 1'b0);
      {4'h6, 2'h2}: res = mk(2'h1, smlt_pkg::SIZ_WORD, 1'b0);
      // Tribytes
      {4'h8, 2'h0}: res = mk(2'h0, smlt_pkg::SIZ_TRI, 1'b0);
      {4'h8, 2'h3}: res = mk(2'h1, smlt_pkg::SIZ_TRI, 1'b0);
      {4'h1, 2'h0}: res = mk(2'h1, smlt_pkg::SIZ_TRI, 1'b0);
      {4'h1, 2'h3}: res = mk(2'h0, smlt_pkg::SIZ_TRI, 1'b0);
      {4'h2, 2'h1}: res = mk(2'h1, smlt_pkg::SIZ_TRI, 1'b0);
      {4'h2, 2'h2}: res = mk(2'h0, smlt_pkg::SIZ_TRI, 1'b0);
      {4'h4, 2'h2}: res = mk(2'h1, smlt_pkg::SIZ_TRI, 1'b0);
      // Partly legible entry, taken as the mirror of mode 2's 0010 case
      {4'h4, 2'h1}: res = mk(2'h0, smlt_pkg::SIZ_TRI, 1'b0);
      // Longword in every mode
      {4'h0, 2'h0}: res = mk(2'h0, smlt_pkg::SIZ_LONG, 1'b0);
      {4'h0, 2'h1}: res = mk(2'h0, smlt_pkg::SIZ_LONG, 1'b0);
      {4'h0, 2'h2}: res = mk(2'h0, smlt_pkg::SIZ_LONG, 1'b0);
      {4'h0, 2'h3}: res = mk(2'h0, smlt_pkg::SIZ_LONG, 1'b0);
      // 0101, 1010, 1111 and the rest stay illegal
      default: res = '0;
    endcase
  end

endmodule : smlt_down_xlat

/* smlt_top.sv */
// Swap mode lane translator between PCI byte enables and local bus
// address-low and size code, both directions.
// Assumes inputs come from logic on clk_sys; results appear one cycle
// after a request strobe.
module smlt_top (
  input wire logic clk_sys,
  input wire logic reset_n,
  // PCI to local request
  input wire logic down_req,
  input wire logic [3:0] down_be_n,
  input wire smlt_pkg::smlt_swp_t down_page_swap_select,
  output smlt_pkg::smlt_local_s down_loc_q,
  output logic down_low_lane_q,
  output logic down_go_q,
  output logic down_abort_q,
  output logic down_d64_swap_q,
  // Local to PCI request
  input wire logic up_req,
  input wire smlt_pkg::smlt_local_s up_loc,
  input wire smlt_pkg::smlt_swp_t up_page_swap_select,
  output logic [3:0] up_be_n_q,
  output logic up_low_lane_q,
  output logic up_go_q,
  output logic up_abort_q,
  output logic up_d64_swap_q
);

  // Translator results and the take or refuse decision per side
  smlt_pkg::smlt_down_s down_res;
  smlt_pkg::smlt_up_s up_res;
  logic [1:0] down_mode;
  logic [1:0] up_mode;
  logic down_take;
  logic down_refuse;
  logic up_take;
  logic up_refuse;
  // Next values of the down side registers
  smlt_pkg::smlt_local_s down_loc_d;
  logic down_low_lane_d;
  logic down_go_d;
  logic down_abort_d;
  logic down_d64_swap_d;
  // Next values of the up side registers
  logic [3:0] up_be_n_d;
  logic up_low_lane_d;
  logic up_go_d;
  logic up_abort_d;
  logic up_d64_swap_d;

  // Mode select from a page entry
  function automatic logic [1:0] mode_of(input smlt_pkg::smlt_swp_t s);
    return s[smlt_pkg::SWP_MODE_LSB +: 2];
  endfunction : mode_of

  // Quadword swap flag; only meaningful for D64 block transfers
  function automatic logic d64_of(input smlt_pkg::smlt_swp_t s);
    return s[smlt_pkg::SWP_D64_BIT];
  endfunction : d64_of

  // A request is carried out only when the table has an entry for it
  function automatic logic take_of(input logic req, input logic legal);
    return req && legal;
  endfunction : take_of

  // A request with no table entry is refused rather than guessed at
  function automatic logic refuse_of(input logic req, input logic legal);
    return req && !legal;
  endfunction : refuse_of

  assign down_mode = mode_of(down_page_swap_select);
  assign up_mode = mode_of(up_page_swap_select);

  smlt_down_xlat i_smlt_down_xlat (
    .be_n(down_be_n),
    .mode(down_mode),
    .res(down_res)
  );

  smlt_up_xlat i_smlt_up_xlat (
    .loc(up_loc),
    .mode(up_mode),
    .res(up_res)
  );

  // Down side: forward only what the table defines
  always_comb begin
    down_take = take_of(down_req, down_res.legal);
  end

  // Down side: anything else is aborted back on PCI
  always_comb begin
    down_refuse = refuse_of(down_req, down_res.legal);
  end

  // Up side: noncontiguous enables are table entries and still go out
  always_comb begin
    up_take = take_of(up_req, up_res.legal);
  end

  // Up side: codes outside the table never reach PCI
  always_comb begin
    up_refuse = refuse_of(up_req, up_res.legal);
  end

  // Strobes last one cycle; a held request repeats them
  always_comb begin
    down_go_d = down_take;
  end

  always_comb begin
    down_abort_d = down_refuse;
  end

  // Data outputs keep the last legal request; a refusal leaves them
  always_comb begin
    if (down_take) begin
      down_loc_d = down_res.loc;
    end else begin
      down_loc_d = down_loc_q;
    end
  end

  always_comb begin
    if (down_take) begin
      down_low_lane_d = down_res.low_lane;
    end else begin
      down_low_lane_d = down_low_lane_q;
    end
  end

  always_comb begin
    if (down_take) begin
      down_d64_swap_d = d64_of(down_page_swap_select);
    end else begin
      down_d64_swap_d = down_d64_swap_q;
    end
  end

  // Up strobes follow the same one-cycle pattern
  always_comb begin
    up_go_d = up_take;
  end

  always_comb begin
    up_abort_d = up_refuse;
  end

  // Enables hold until the next legal request
  always_comb begin
    if (up_take) begin
      up_be_n_d = up_res.be_n;
    end else begin
      up_be_n_d = up_be_n_q;
    end
  end

  always_comb begin
    if (up_take) begin
      up_low_lane_d = up_res.low_lane;
    end else begin
      up_low_lane_d = up_low_lane_q;
    end
  end

  always_comb begin
    if (up_take) begin
      up_d64_swap_d = d64_of(up_page_swap_select);
    end else begin
      up_d64_swap_d = up_d64_swap_q;
    end
  end

  // Forward strobe toward the local bus
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      down_go_q <= 1'b0;
    end else begin
      down_go_q <= down_go_d;
    end
  end

  // Abort strobe back to PCI
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      down_abort_q <= 1'b0;
    end else begin
      down_abort_q <= down_abort_d;
    end
  end

  // Local address-low and size code
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      down_loc_q <= '0;
    end else begin
      down_loc_q <= down_loc_d;
    end
  end

  // Low lane flag for the local transfer
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      down_low_lane_q <= 1'b0;
    end else begin
      down_low_lane_q <= down_low_lane_d;
    end
  end

  // Quadword swap flag, down side
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      down_d64_swap_q <= 1'b0;
    end else begin
      down_d64_swap_q <= down_d64_swap_d;
    end
  end

  // Issue strobe toward PCI
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      up_go_q <= 1'b0;
    end else begin
      up_go_q <= up_go_d;
    end
  end

  // Refusal strobe for undefined local codes
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      up_abort_q <= 1'b0;
    end else begin
      up_abort_q <= up_abort_d;
    end
  end

  // PCI enables idle with no byte enabled
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      up_be_n_q <= smlt_pkg::BE_NONE;
    end else begin
      up_be_n_q <= up_be_n_d;
    end
  end

  // Low lane flag for the received data
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      up_low_lane_q <= 1'b0;
    end else begin
      up_low_lane_q <= up_low_lane_d;
    end
  end

  // Quadword swap flag, up side
  always_ff @(posedge clk_sys) begin
    if (!reset_n) begin
      up_d64_swap_q <= 1'b0;
    end else begin
      up_d64_swap_q <= up_d64_swap_d;
    end
  end

endmodule : smlt_top

/* smlt_up_xlat.sv */
// Local address-low and size to PCI byte enables, per swap mode.
// Pure combinational table; the top registers its result.
module smlt_up_xlat (
  input wire smlt_pkg::smlt_local_s loc,
  input wire logic [1:0] mode,
  output smlt_pkg::smlt_up_s res
);

  function automatic logic [3:0] pick(input logic [1:0] m,
    input logic [3:0] b0, input logic [3:0] b1,
    input logic [3:0] b2, input logic [3:0] b3);
    logic [3:0] r;
    r = b0;
    unique case (m)
      2'h0: r = b0;
      2'h1: r = b1;
      2'h2: r = b2;
      2'h3: r = b3;
    endcase
    return r;
  endfunction : pick

  always_comb begin
    res.legal = 1'b1;
    res.low_lane = 1'b0;
    res.be_n = smlt_pkg::BE_NONE;
    unique case ({loc.local_address_low_bits, loc.local_transfer_size_code})
      4'h0: res.be_n = smlt_pkg::BE_ALL;
      4'h3: res.be_n = pick(mode, 4'h8, 4'h4, 4'h2, 4'h1);
      4'h7: res.be_n = pick(mode, 4'h1, 4'h2, 4'h4, 4'h8);
      4'h2: begin
        res.be_n = pick(mode, 4'hC, 4'hC, 4'h3, 4'h3);
        res.low_lane = 1'b1;
      end
      4'h6: res.be_n = pick(mode, 4'h9, 4'h6, 4'h6, 4'h9);
      4'hA: res.be_n = pick(mode, 4'h3, 4'h3, 4'hC, 4'hC);
      4'h1: begin
        res.be_n = pick(mode, 4'hE, 4'hD, 4'hB, 4'h7);
        res.low_lane = 1'b1;
      end
      4'h5: begin
        res.be_n = pick(mode, 4'hD, 4'hE, 4'h7, 4'hB);
        res.low_lane = 1'b1;
      end
      4'h9: res.be_n = pick(mode, 4'hB, 4'h7, 4'hE, 4'hD);
      4'hD: res.be_n = pick(mode, 4'h7, 4'hB, 4'hD, 4'hE);
      // Codes outside the table have no defined lanes
      default: res.legal = 1'b0;
    endcase
  end

endmodule : smlt_up_xlat

/* smlt_checker.sv */
// Timing and table checks on the translator top ports.
// Assumes one clk_sys domain and a synchronous active-low reset.
module smlt_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic down_req,
  input wire logic [3:0] down_be_n,
  input wire smlt_pkg::smlt_swp_t down_page_swap_select,
  input wire smlt_pkg::smlt_local_s down_loc_q,
  input wire logic down_low_lane_q,
  input wire logic down_go_q,
  input wire logic down_abort_q,
  input wire logic down_d64_swap_q,
  input wire logic up_req,
  input wire smlt_pkg::smlt_local_s up_loc,
  input wire smlt_pkg::smlt_swp_t up_page_swap_select,
  input wire logic [3:0] up_be_n_q,
  input wire logic up_low_lane_q,
  input wire logic up_go_q,
  input wire logic up_abort_q,
  input wire logic up_d64_swap_q
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  dn_answer_a: assert property (down_req |=>
    down_go_q != down_abort_q) else $error("down answer wrong");
  // Past reset gate: a one-edge reset clears outputs without a go pulse
  dn_hold_a: assert property (!down_go_q && $past(reset_n) |->
    $stable(down_loc_q) && $stable(down_low_lane_q))
    else $error("down data moved");
  dn_full_a: assert property (down_req && down_be_n == 4'h0 |=>
    down_go_q && down_loc_q == 4'h0) else $error("down full wrong");
  dn_split_a: assert property (down_req &&
    (down_be_n == 4'h5 || down_be_n == 4'hA) |=> down_abort_q && !down_go_q)
    else $error("down split passed");
  dn_d64_a: assert property (down_go_q |->
    down_d64_swap_q == $past(down_page_swap_select[2]))
    else $error("down d64 wrong");
  up_answer_a: assert property (up_req |=>
    up_go_q != up_abort_q) else $error("up answer wrong");
  up_full_a: assert property (up_req && up_loc == 4'h0 |=>
    up_go_q && up_be_n_q == 4'h0) else $error("up full wrong");
  up_byte_a: assert property (up_req && up_loc[1:0] == 2'h1 |=>
    up_go_q && $countones(up_be_n_q) == 3) else $error("up byte wrong");
  up_hold_a: assert property (!up_go_q && $past(reset_n) |->
    $stable(up_be_n_q) && $stable(up_low_lane_q))
    else $error("up data moved");
endmodule : smlt_checker

/* smlt_partner.sv */
// Model of the interface controller driving the local bus side.
// Assumes the bench issues commands on the falling clock edge.
module smlt_partner (
  input wire logic clk_sys,
  input wire logic cmd_req,
  input wire smlt_pkg::smlt_local_s cmd_loc,
  input wire smlt_pkg::smlt_swp_t cmd_sel,
  output logic up_req,
  output smlt_pkg::smlt_local_s up_loc,
  output smlt_pkg::smlt_swp_t up_page_swap_select
);
  timeunit 1ns;
  timeprecision 1ps;
  smlt_pkg::smlt_local_s last_q = 4'h0;
  assign up_req = cmd_req;
  // Released up_loc lines show the inverse of the last drive, never a held value
  assign up_loc = cmd_req ? cmd_loc : ~last_q;
  assign up_page_swap_select = cmd_req ? cmd_sel : 3'h5;
  always_ff @(posedge clk_sys) begin
    if (cmd_req) begin
      last_q <= cmd_loc;
    end
  end
endmodule : smlt_partner

/* smlt_top_bench.sv */
// Bench walking both translation tables in all modes, back to back.
// Assumes smlt_pkg, smlt_top, smlt_partner and smlt_checker compiled.
module smlt_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  `define CHK(nm, e, a) begin n_tests++; if ((a) !== (e)) begin \
    $display("unexpected %s exp %h got %h", nm, e, a); \
    err_count++; end end
  // Per be_n, a byte per mode 0..3: legal, low lane, addr low, size
  localparam logic [31:0] DN [16] = '{32'h20202020, 32'h27000023,
    32'h00272300, 32'h2A2A3232, 32'h00232700, 32'h0, 32'h00262600,
    32'h2D293531, 32'h23000027, 32'h26000026, 32'h0, 32'h292D3135,
    32'h32322A2A, 32'h35312D29, 32'h3135292D, 32'h0};
  // Per local code, a be_n nibble per mode 0..3
  localparam logic [15:0] UP [16] = '{16'h0, 16'hEDB7, 16'hCC33, 16'h8421,
    16'h0, 16'hDE7B, 16'h9669, 16'h1248, 16'h0, 16'hB7ED, 16'h33CC,
    16'h0, 16'h0, 16'h7BDE, 16'h0, 16'h0};
  logic clk_sys = 1'b0;
  logic reset_n = 1'b0;
  logic down_req = 1'b0;
  logic [3:0] down_be_n = 4'hF;
  smlt_pkg::smlt_swp_t down_page_swap_select = 3'h0;
  smlt_pkg::smlt_local_s down_loc_q;
  logic down_low_lane_q, down_go_q, down_abort_q, down_d64_swap_q;
  logic cmd_req = 1'b0;
  smlt_pkg::smlt_local_s cmd_loc = 4'h0;
  smlt_pkg::smlt_swp_t cmd_sel = 3'h0;
  logic up_req;
  smlt_pkg::smlt_local_s up_loc;
  smlt_pkg::smlt_swp_t up_page_swap_select;
  logic [3:0] up_be_n_q;
  logic up_low_lane_q, up_go_q, up_abort_q, up_d64_swap_q;
  logic [4:0] dn_exp = 5'h0;
  logic [4:0] up_exp = 5'h0F;
  int err_count = 0;
  int n_tests = 0;
  int cyc = 0;
  smlt_top i_smlt_top (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .down_req(down_req),
    .down_be_n(down_be_n),
    .down_page_swap_select(down_page_swap_select),
    .down_loc_q(down_loc_q),
    .down_low_lane_q(down_low_lane_q),
    .down_go_q(down_go_q),
    .down_abort_q(down_abort_q),
    .down_d64_swap_q(down_d64_swap_q),
    .up_req(up_req),
    .up_loc(up_loc),
    .up_page_swap_select(up_page_swap_select),
    .up_be_n_q(up_be_n_q),
    .up_low_lane_q(up_low_lane_q),
    .up_go_q(up_go_q),
    .up_abort_q(up_abort_q),
    .up_d64_swap_q(up_d64_swap_q)
  );
  smlt_partner i_smlt_partner (
    .clk_sys(clk_sys),
    .cmd_req(cmd_req),
    .cmd_loc(cmd_loc),
    .cmd_sel(cmd_sel),
    .up_req(up_req),
    .up_loc(up_loc),
    .up_page_swap_select(up_page_swap_select)
  );
  initial forever #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 2000) begin
      err_count++;
      tally_and_finish;
    end
  end
  task tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : tally_and_finish
  task dn_one(input logic [3:0] be, input logic [2:0] sel);
    logic [7:0] e;
    e = 8'(DN[be] >> (24 - 8 * int'(sel[1:0])));
    down_req <= 1'b1;
    down_be_n <= be;
    down_page_swap_select <= sel;
    @(negedge clk_sys);
    if (e[5]) dn_exp = e[4:0];
    `CHK("dn_go", e[5], down_go_q)
    `CHK("dn_abort", ~e[5], down_abort_q)
    `CHK("dn_map", dn_exp, {down_low_lane_q, down_loc_q})
    if (e[5]) `CHK("dn_d64", sel[2], down_d64_swap_q)
  endtask : dn_one
  task up_one(input logic [3:0] lc, input logic [2:0] sel);
    logic ok;
    ok = 1'(16'h26EF >> lc);
    cmd_req <= 1'b1;
    cmd_loc <= lc;
    cmd_sel <= sel;
    @(negedge clk_sys);
    if (ok) up_exp = {1'(16'h0026 >> lc),
      4'(UP[lc] >> (12 - 4 * int'(sel[1:0])))};
    `CHK("up_go", ok, up_go_q)
    `CHK("up_abort", ~ok, up_abort_q)
    `CHK("up_map", up_exp, {up_low_lane_q, up_be_n_q})
    if (ok) `CHK("up_d64", sel[2], up_d64_swap_q)
  endtask : up_one
  task t_reset;
    repeat (3) @(negedge clk_sys);
    `CHK("rst_dn", 2'h0, {down_go_q, down_abort_q})
    `CHK("rst_up", 5'h0F, {up_low_lane_q, up_be_n_q})
    reset_n <= 1'b1;
    @(negedge clk_sys);
    $display("test reset done");
  endtask : t_reset
  task t_down;
    for (int s = 0; s < 8; s++)
      for (int b = 0; b < 16; b++) dn_one(4'(b), 3'(s));
    down_req <= 1'b0;
    @(negedge clk_sys);
    `CHK("dn_idle", 2'h0, {down_go_q, down_abort_q})
    $display("test down done");
  endtask : t_down
  task t_up;
    for (int s = 0; s < 8; s++)
      for (int c = 0; c < 16; c++) up_one(4'(c), 3'(s));
    cmd_req <= 1'b0;
    @(negedge clk_sys);
    `CHK("up_idle", 2'h0, {up_go_q, up_abort_q})
    $display("test up done");
  endtask : t_up
  // Reset in mid-run clears held data; a refusal must not bring it back
  task t_midreset;
    reset_n <= 1'b0;
    repeat (2) @(negedge clk_sys);
    `CHK("mid_dn", 5'h0, {down_low_lane_q, down_loc_q})
    `CHK("mid_up", 5'h0F, {up_low_lane_q, up_be_n_q})
    `CHK("mid_d64", 2'h0, {down_d64_swap_q, up_d64_swap_q})
    dn_exp = 5'h0;
    up_exp = 5'h0F;
    reset_n <= 1'b1;
    @(negedge clk_sys);
    dn_one(4'hA, 3'h5);
    dn_one(4'hC, 3'h2);
    down_req <= 1'b0;
    up_one(4'hE, 3'h4);
    up_one(4'h2, 3'h3);
    cmd_req <= 1'b0;
    @(negedge clk_sys);
    `CHK("mid_idle", 4'h0, {down_go_q, down_abort_q, up_go_q, up_abort_q})
    $display("test midreset done");
  endtask : t_midreset
  initial begin
    t_reset;
    t_down;
    t_up;
    t_midreset;
    tally_and_finish;
  end
endmodule : smlt_top_bench
bind smlt_top smlt_checker i_smlt_checker (
  .clk_sys(clk_sys),
  .reset_n(reset_n),
  .down_req(down_req),
  .down_be_n(down_be_n),
  .down_page_swap_select(down_page_swap_select),
  .down_loc_q(down_loc_q),
  .down_low_lane_q(down_low_lane_q),
  .down_go_q(down_go_q),
  .down_abort_q(down_abort_q),
  .down_d64_swap_q(down_d64_swap_q),
  .up_req(up_req),
  .up_loc(up_loc),
  .up_page_swap_select(up_page_swap_select),
  .up_be_n_q(up_be_n_q),
  .up_low_lane_q(up_low_lane_q),
  .up_go_q(up_go_q),
  .up_abort_q(up_abort_q),
  .up_d64_swap_q(up_d64_swap_q)
);
